// ### logic/radio_dongle.sv
// receiver dongle end of the radio packet protocol
`timescale 1ns/10ps
module radio_dongle #(
	parameter int unsigned LOSS_WAIT = radio_pkt_pkg::SAMPLE_PERIOD_CYC,
	parameter int unsigned CONNECT_WAIT = radio_pkt_pkg::CONNECT_WAIT_CYC
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	radio_link_if.dongle_mp LINK,
	input wire logic [7:0] LQ_I,
	input wire logic CAL_REQ_I,
	input wire logic [47:0] CAL_DATA_I,
	input wire logic RANGE_REQ_I,
	input wire logic [1:0] RANGE_I,
	output logic CONNECTED_O,
	output logic [15:0] NET_ID_O,
	output logic [7:0] PEER_LQ_O,
	output logic [47:0] CAL_STORED_O,
	output logic TX_ABORT_O,
	output logic SAMPLE_VALID_O,
	input wire logic SAMPLE_READY_I,
	output logic [79:0] SAMPLE_O
);
	typedef enum logic [3:0] {
		ST_START = 4'b0001,
		ST_BCAST = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_LINK = 4'b1000
	} conn_e;
	conn_e state, next_state;
	logic [15:0] lfsr;
	logic [15:0] net_id;
	logic tx_busy;
	logic [4:0] tx_idx;
	logic [4:0] tx_len;
	logic [7:0] tx_cmd;
	logic [7:0] tx_lq;
	logic [79:0] tx_pay;
	logic [7:0] tx_wait;
	logic [4:0] rx_idx;
	logic [47:0] rx_hdr;
	logic [79:0] rx_pay;
	logic rx_done;
	logic [31:0] timer;
	logic [2:0] miss;
	logic cal_pend;
	logic [47:0] cal_val;
	logic rng_pend;
	logic [1:0] rng_val;
	logic reply_pend;
	logic [79:0] buf_mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] buf_cnt;

	// ****************************************
	// decode
	// ****************************************
	wire tx_fire = LINK.d2s_valid & LINK.d2s_ready;
	wire tx_end = tx_fire & LINK.d2s_last;
	wire tx_expire = tx_busy & CE_I & ~LINK.d2s_ready
		& (tx_wait == radio_pkt_pkg::TX_TIMEOUT_CYC - 8'h01);
	wire rx_fire = LINK.s2d_valid & LINK.s2d_ready;
	wire hdr_ok = (rx_hdr[47:32] == radio_pkt_pkg::FRAME_CTRL)
		& (rx_hdr[31:16] == net_id); // RULE2
	wire [7:0] rx_cmd = rx_hdr[7:0];
	wire got_conn = rx_done & hdr_ok & (rx_cmd == radio_pkt_pkg::CMD_CONNECT_REPLY)
		& (rx_idx == radio_pkt_pkg::HDR_LEN + radio_pkt_pkg::CAL_LEN)
		& ((state == ST_WAIT) | (state == ST_LINK));
	wire got_sample = rx_done & hdr_ok & (rx_cmd == radio_pkt_pkg::CMD_SENSOR_SAMPLE)
		& (rx_idx == radio_pkt_pkg::HDR_LEN + radio_pkt_pkg::SAMPLE_LEN)
		& (state == ST_LINK);
	wire launch_bcast = (state == ST_BCAST); // RULE7
	wire launch_reply = (state == ST_LINK) & reply_pend & ~tx_busy;
	wire timer_out = (timer == 32'h0);
	wire miss_final = (miss + 3'h1 == radio_pkt_pkg::MISS_LIMIT); // RULE13 RULE17
	wire pop = SAMPLE_VALID_O & SAMPLE_READY_I;
	// reply choice: pending settings ride in place of the acknowledge
	wire [7:0] reply_cmd = cal_pend ? radio_pkt_pkg::CMD_CALIBRATION_PUSH :
		rng_pend ? radio_pkt_pkg::CMD_RANGE_SELECT :
		radio_pkt_pkg::CMD_DATA_ACKNOWLEDGE; // RULE10 RULE14 RULE15
	wire [4:0] reply_len = cal_pend ? radio_pkt_pkg::HDR_LEN + radio_pkt_pkg::CAL_LEN :
		rng_pend ? radio_pkt_pkg::HDR_LEN + radio_pkt_pkg::RANGE_LEN :
		radio_pkt_pkg::HDR_LEN; // RULE5
	wire [79:0] reply_pay = cal_pend ? {cal_val, 32'h0} :
		rng_pend ? {6'h0, rng_val, 72'h0} : 80'h0;
	// header byte order: frame control, network id, quality, command
	wire [7:0] tx_byte = (tx_idx == 5'h00) ? radio_pkt_pkg::FRAME_CTRL[15:8] : // RULE6
		(tx_idx == 5'h01) ? radio_pkt_pkg::FRAME_CTRL[7:0] :
		(tx_idx == 5'h02) ? net_id[15:8] : // RULE1
		(tx_idx == 5'h03) ? net_id[7:0] :
		(tx_idx == 5'h04) ? tx_lq : // RULE3
		(tx_idx == 5'h05) ? tx_cmd : tx_pay[79:72]; // RULE4 RULE5
	assign LINK.d2s_valid = tx_busy & CE_I;
	assign LINK.d2s_data = tx_byte;
	assign LINK.d2s_last = (tx_idx == tx_len - 5'h01);
	// no byte is taken while a finished packet is judged or the buffer is full
	assign LINK.s2d_ready = CE_I & ~rx_done & (buf_cnt != 2'h2);
	assign SAMPLE_VALID_O = CE_I & (buf_cnt != 2'h0);
	assign SAMPLE_O = buf_mem[rd_ptr];
	assign CONNECTED_O = (state == ST_LINK);
	assign NET_ID_O = net_id;

	// ****************************************
	// connection state machine
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			ST_START: if (~tx_busy) next_state = ST_BCAST;
			ST_BCAST: next_state = ST_WAIT;
			ST_WAIT: begin
				if (got_conn) next_state = ST_LINK;
				else if (timer_out) next_state = ST_START;
			end
			ST_LINK: if (~got_sample & timer_out & miss_final) next_state = ST_START; // RULE13
			default: next_state = ST_START;
		endcase
	end

	// free-running id source, advances on every clock-enabled cycle
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) lfsr <= radio_pkt_pkg::LFSR_SEED;
		else if (CE_I) lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]}; // RULE18
	end

	// state, network id, loss timer and miss count
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= ST_START;
			net_id <= 16'h0;
			timer <= 32'h0;
			miss <= 3'h0;
		end else if (CE_I) begin
			state <= next_state;
			if ((state == ST_START) & ~tx_busy) net_id <= lfsr; // RULE7 RULE18
			if (launch_bcast) timer <= CONNECT_WAIT;
			else if (got_conn & (state == ST_WAIT)) timer <= LOSS_WAIT;
			else if (got_sample | timer_out) timer <= LOSS_WAIT;
			else timer <= timer - 32'h1;
			if (got_sample | (state != ST_LINK)) miss <= 3'h0;
			else if (timer_out) miss <= miss + 3'h1; // RULE13
		end
	end

	// pending settings: a new request in the clearing cycle wins
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cal_pend <= 1'b0;
			cal_val <= radio_pkt_pkg::CAL_RESET;
			rng_pend <= 1'b0;
			rng_val <= radio_pkt_pkg::RANGE_RESET;
			reply_pend <= 1'b0;
		end else if (CE_I) begin
			if (got_conn) cal_pend <= 1'b0; // RULE14
			if (got_conn) rng_pend <= 1'b0; // RULE15
			if (CAL_REQ_I) begin
				cal_pend <= 1'b1;
				cal_val <= CAL_DATA_I;
			end
			if (RANGE_REQ_I) begin
				rng_pend <= 1'b1;
				rng_val <= RANGE_I;
			end
			if (got_sample) reply_pend <= 1'b1; // RULE10
			else if (launch_reply | (state != ST_LINK)) reply_pend <= 1'b0;
		end
	end

	// ****************************************
	// transmit engine
	// ****************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tx_busy <= 1'b0;
			tx_idx <= 5'h00;
			tx_len <= 5'h00;
			tx_cmd <= 8'h00;
			tx_lq <= 8'h00;
			tx_pay <= 80'h0;
			tx_wait <= 8'h00;
			TX_ABORT_O <= 1'b0;
		end else if (CE_I) begin
			TX_ABORT_O <= tx_expire;
			if (launch_bcast | launch_reply) begin
				tx_busy <= 1'b1;
				tx_idx <= 5'h00;
				tx_lq <= LQ_I; // RULE3
				tx_cmd <= launch_bcast ? radio_pkt_pkg::CMD_CONNECT_BROADCAST : reply_cmd;
				tx_len <= launch_bcast ? radio_pkt_pkg::HDR_LEN : reply_len; // RULE7
				tx_pay <= launch_bcast ? 80'h0 : reply_pay;
				tx_wait <= 8'h00;
			end else if (tx_end | tx_expire) begin
				tx_busy <= 1'b0; // RULE16
				tx_idx <= 5'h00;
			end else if (tx_fire) begin
				tx_idx <= tx_idx + 5'h01;
				tx_wait <= 8'h00;
				if (tx_idx >= radio_pkt_pkg::HDR_LEN) tx_pay <= {tx_pay[71:0], 8'h00};
			end else if (tx_busy) begin
				// a stuck peer must not hang the engine
				tx_wait <= tx_wait + 8'h01; // RULE16
			end
		end
	end

	// ****************************************
	// receive parser
	// ****************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rx_idx <= 5'h00;
			rx_hdr <= 48'h0;
			rx_pay <= 80'h0;
			rx_done <= 1'b0;
			PEER_LQ_O <= 8'h00;
			CAL_STORED_O <= radio_pkt_pkg::CAL_RESET;
		end else if (CE_I) begin
			rx_done <= rx_fire & LINK.s2d_last;
			if (rx_done) rx_idx <= 5'h00;
			else if (rx_fire) begin
				if (rx_idx != radio_pkt_pkg::IDX_MAX) rx_idx <= rx_idx + 5'h01;
				if (rx_idx < radio_pkt_pkg::HDR_LEN) rx_hdr <= {rx_hdr[39:0], LINK.s2d_data};
				else rx_pay <= {rx_pay[71:0], LINK.s2d_data};
			end
			if (got_conn | got_sample) PEER_LQ_O <= rx_hdr[15:8];
			if (got_conn) CAL_STORED_O <= rx_pay[47:0];
		end
	end

	// ****************************************
	// two-entry sample buffer
	// ****************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			buf_mem[0] <= 80'h0;
			buf_mem[1] <= 80'h0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			buf_cnt <= 2'h0;
		end else if (CE_I) begin
			if (got_sample) begin
				buf_mem[wr_ptr] <= rx_pay;
				wr_ptr <= ~wr_ptr;
			end
			if (pop) rd_ptr <= ~rd_ptr;
			buf_cnt <= buf_cnt + {1'b0, got_sample} - {1'b0, pop};
		end
	end
endmodule

// ### logic/radio_pkt_pkg.sv
// constants shared by both ends of the radio packet link
// Function
// [RULE1] every packet carries 16-bit network id
// [RULE2] drop packets whose network id mismatches
// [RULE3] second field: 8-bit link quality of peer
// [RULE4] third field: 8-bit command code
// [RULE5] command data follows; empty when none
// [RULE6] 16-bit frame control precedes every packet
// [RULE7] dongle connects by broadcasting fresh random id
// [RULE8] sensor answers broadcast/calib/range with connect reply
// [RULE9] sensor sends periodic 10-byte sample packets
// [RULE10] dongle acknowledges every sample packet
// [RULE11] sensor listens more often after missed ack
// [RULE12] sensor drops link after repeated missed acks
// [RULE13] dongle drops link after repeated missing samples
// [RULE14] dongle repeats calibration push until connect reply
// [RULE15] dongle repeats range select until connect reply
// [RULE16] transmit wait abandoned by timeout; dongle only, the sensor transmit engine waits without limit
// [RULE17] miss limit is a constant, default four
// [RULE18] network id sampled from free-running LFSR
package radio_pkt_pkg;
	// ****************************************
	// packet layout
	// ****************************************
	localparam logic [15:0] FRAME_CTRL = 16'h4121;
	localparam logic [7:0] CMD_CONNECT_BROADCAST = 8'h62;
	localparam logic [7:0] CMD_DATA_ACKNOWLEDGE = 8'h61;
	localparam logic [7:0] CMD_CALIBRATION_PUSH = 8'h6b;
	localparam logic [7:0] CMD_RANGE_SELECT = 8'h73;
	localparam logic [7:0] CMD_CONNECT_REPLY = 8'h63;
	localparam logic [7:0] CMD_SENSOR_SAMPLE = 8'h64;
	localparam logic [4:0] HDR_LEN = 5'h06;
	localparam logic [4:0] CAL_LEN = 5'h06;
	localparam logic [4:0] RANGE_LEN = 5'h01;
	localparam logic [4:0] SAMPLE_LEN = 5'h0a;
	localparam logic [4:0] IDX_MAX = 5'h1f;
	// ****************************************
	// reset values and protocol counts
	// ****************************************
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [47:0] CAL_RESET = 48'h0;
	localparam logic [1:0] RANGE_RESET = 2'h0;
	localparam logic [2:0] MISS_LIMIT = 3'h4;
	localparam logic [1:0] ACK_SKIP_MASK = 2'h3;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TX_TIMEOUT_NS = 2000;
	localparam logic [7:0] TX_TIMEOUT_CYC = 8'((TX_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int unsigned SAMPLE_PERIOD_US = 5000;
	localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned LISTEN_WINDOW_US = 1000;
	localparam int unsigned LISTEN_WINDOW_CYC = LISTEN_WINDOW_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CONNECT_WAIT_US = 20000;
	localparam int unsigned CONNECT_WAIT_CYC = CONNECT_WAIT_US * 1000 / CLK_PERIOD_NS;
endpackage

// ### logic/radio_link_if.sv
// byte-stream link joining the dongle and the sensor board
`timescale 1ns/10ps
interface radio_link_if;
	logic d2s_valid;
	logic d2s_ready;
	logic [7:0] d2s_data;
	logic d2s_last;
	logic s2d_valid;
	logic s2d_ready;
	logic [7:0] s2d_data;
	logic s2d_last;
	modport dongle_mp (
		output d2s_valid, d2s_data, d2s_last, s2d_ready,
		input d2s_ready, s2d_valid, s2d_data, s2d_last
	);
	modport sensor_mp (
		input d2s_valid, d2s_data, d2s_last, s2d_ready,
		output d2s_ready, s2d_valid, s2d_data, s2d_last
	);
endinterface

// ### logic/radio_sensor.sv
// sensor board end of the radio packet protocol
`timescale 1ns/10ps
module radio_sensor #(
	parameter int unsigned SAMPLE_PERIOD = radio_pkt_pkg::SAMPLE_PERIOD_CYC,
	parameter int unsigned LISTEN_WINDOW = radio_pkt_pkg::LISTEN_WINDOW_CYC
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	radio_link_if.sensor_mp LINK,
	input wire logic [7:0] LQ_I,
	input wire logic [79:0] SAMPLE_I,
	output logic CONNECTED_O,
	output logic [15:0] NET_ID_O,
	output logic [7:0] PEER_LQ_O,
	output logic [47:0] CAL_O,
	output logic [1:0] RANGE_O
);
	typedef enum logic [1:0] {
		ST_SEARCH = 2'b01,
		ST_LINK = 2'b10
	} conn_e;
	conn_e state;
	logic [15:0] net_id;
	logic tx_busy;
	logic [4:0] tx_idx;
	logic [4:0] tx_len;
	logic [7:0] tx_cmd;
	logic [7:0] tx_lq;
	logic [79:0] tx_pay;
	logic [4:0] rx_idx;
	logic [47:0] rx_hdr;
	logic [79:0] rx_pay;
	logic rx_done;
	logic [31:0] period;
	logic [31:0] win_timer;
	logic win_open;
	logic missed;
	logic [2:0] miss;
	logic [1:0] pkt_cnt;
	logic conn_pend;
	logic data_pend;

	// ****************************************
	// decode
	// ****************************************
	wire tx_fire = LINK.s2d_valid & LINK.s2d_ready;
	wire tx_end = tx_fire & LINK.s2d_last;
	wire rx_fire = LINK.d2s_valid & LINK.d2s_ready;
	wire fc_ok = (rx_hdr[47:32] == radio_pkt_pkg::FRAME_CTRL);
	wire [7:0] rx_cmd = rx_hdr[7:0];
	wire got_bcast = rx_done & fc_ok & (state == ST_SEARCH) & ~tx_busy
		& (rx_cmd == radio_pkt_pkg::CMD_CONNECT_BROADCAST)
		& (rx_idx == radio_pkt_pkg::HDR_LEN);
	// replies count only inside an open window and on our own network
	wire in_win = rx_done & fc_ok & win_open & (rx_hdr[31:16] == net_id); // RULE2
	wire got_ack = in_win & (rx_cmd == radio_pkt_pkg::CMD_DATA_ACKNOWLEDGE)
		& (rx_idx == radio_pkt_pkg::HDR_LEN);
	wire got_cal = in_win & (rx_cmd == radio_pkt_pkg::CMD_CALIBRATION_PUSH)
		& (rx_idx == radio_pkt_pkg::HDR_LEN + radio_pkt_pkg::CAL_LEN);
	wire got_rng = in_win & (rx_cmd == radio_pkt_pkg::CMD_RANGE_SELECT)
		& (rx_idx == radio_pkt_pkg::HDR_LEN + radio_pkt_pkg::RANGE_LEN);
	wire got_reply = got_ack | got_cal | got_rng;
	wire win_out = win_open & (win_timer == 32'h0) & ~got_reply;
	wire miss_final = (miss + 3'h1 == radio_pkt_pkg::MISS_LIMIT); // RULE12 RULE17
	wire launch_conn = (state == ST_LINK) & conn_pend & ~tx_busy; // RULE8
	wire launch_data = (state == ST_LINK) & ~conn_pend & data_pend & ~tx_busy; // RULE9
	// listen after every fourth sample, or after each one once an ack went missing
	wire want_win = (pkt_cnt == 2'h0) | missed; // RULE10 RULE11
	wire [7:0] tx_byte = (tx_idx == 5'h00) ? radio_pkt_pkg::FRAME_CTRL[15:8] : // RULE6
		(tx_idx == 5'h01) ? radio_pkt_pkg::FRAME_CTRL[7:0] :
		(tx_idx == 5'h02) ? net_id[15:8] : // RULE1
		(tx_idx == 5'h03) ? net_id[7:0] :
		(tx_idx == 5'h04) ? tx_lq : // RULE3
		(tx_idx == 5'h05) ? tx_cmd : tx_pay[79:72]; // RULE4 RULE5
	assign LINK.s2d_valid = tx_busy & CE_I;
	assign LINK.s2d_data = tx_byte;
	assign LINK.s2d_last = (tx_idx == tx_len - 5'h01);
	assign LINK.d2s_ready = CE_I & ~rx_done;
	assign CONNECTED_O = (state == ST_LINK);
	assign NET_ID_O = net_id;

	// ****************************************
	// connection control
	// ****************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= ST_SEARCH;
			net_id <= 16'h0;
			period <= 32'h0;
			win_timer <= 32'h0;
			win_open <= 1'b0;
			missed <= 1'b0;
			miss <= 3'h0;
			pkt_cnt <= 2'h0;
			conn_pend <= 1'b0;
			data_pend <= 1'b0;
			CAL_O <= radio_pkt_pkg::CAL_RESET;
			RANGE_O <= radio_pkt_pkg::RANGE_RESET;
		end else if (CE_I) begin
			unique case (state)
				ST_SEARCH: begin
					if (got_bcast) begin
						state <= ST_LINK;
						net_id <= rx_hdr[31:16]; // RULE7
						conn_pend <= 1'b1; // RULE8
						period <= SAMPLE_PERIOD;
						miss <= 3'h0;
						missed <= 1'b0;
						pkt_cnt <= 2'h0;
						data_pend <= 1'b0;
					end
				end
				ST_LINK: begin
					if (period == 32'h0) period <= SAMPLE_PERIOD;
					else period <= period - 32'h1;
					if (launch_conn) conn_pend <= 1'b0;
					if (launch_data) data_pend <= 1'b0;
					// a tick in the launch cycle must not be lost to the clear
					if (period == 32'h0) data_pend <= 1'b1; // RULE9
					if (got_cal | got_rng) conn_pend <= 1'b1; // RULE8
					if (got_cal) CAL_O <= rx_pay[47:0];
					if (got_rng) RANGE_O <= rx_pay[1:0];
					if (tx_end & (tx_cmd == radio_pkt_pkg::CMD_SENSOR_SAMPLE)) begin
						pkt_cnt <= (pkt_cnt + 2'h1) & radio_pkt_pkg::ACK_SKIP_MASK;
						if (want_win) begin
							win_open <= 1'b1;
							win_timer <= LISTEN_WINDOW;
						end
					end else if (got_reply) begin
						win_open <= 1'b0;
						missed <= 1'b0;
						miss <= 3'h0;
					end else if (win_out) begin
						win_open <= 1'b0;
						missed <= 1'b1; // RULE11
						miss <= miss + 3'h1;
						if (miss_final) state <= ST_SEARCH; // RULE12
					end else if (win_open) win_timer <= win_timer - 32'h1;
				end
				default: state <= ST_SEARCH;
			endcase
		end
	end

	// ****************************************
	// transmit engine
	// ****************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tx_busy <= 1'b0;
			tx_idx <= 5'h00;
			tx_len <= 5'h00;
			tx_cmd <= 8'h00;
			tx_lq <= 8'h00;
			tx_pay <= 80'h0;
		end else if (CE_I) begin
			if (launch_conn | launch_data) begin
				tx_busy <= 1'b1;
				tx_idx <= 5'h00;
				tx_lq <= LQ_I; // RULE3
				tx_cmd <= launch_conn ? radio_pkt_pkg::CMD_CONNECT_REPLY :
					radio_pkt_pkg::CMD_SENSOR_SAMPLE;
				tx_len <= radio_pkt_pkg::HDR_LEN + (launch_conn ?
					radio_pkt_pkg::CAL_LEN : radio_pkt_pkg::SAMPLE_LEN); // RULE9
				tx_pay <= launch_conn ? {CAL_O, 32'h0} : SAMPLE_I;
			end else if (tx_end) begin
				tx_busy <= 1'b0;
				tx_idx <= 5'h00;
			end else if (tx_fire) begin
				tx_idx <= tx_idx + 5'h01;
				if (tx_idx >= radio_pkt_pkg::HDR_LEN) tx_pay <= {tx_pay[71:0], 8'h00};
			end
		end
	end

	// ****************************************
	// receive parser
	// ****************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rx_idx <= 5'h00;
			rx_hdr <= 48'h0;
			rx_pay <= 80'h0;
			rx_done <= 1'b0;
			PEER_LQ_O <= 8'h00;
		end else if (CE_I) begin
			rx_done <= rx_fire & LINK.d2s_last;
			if (rx_done) rx_idx <= 5'h00;
			else if (rx_fire) begin
				if (rx_idx != radio_pkt_pkg::IDX_MAX) rx_idx <= rx_idx + 5'h01;
				if (rx_idx < radio_pkt_pkg::HDR_LEN) rx_hdr <= {rx_hdr[39:0], LINK.d2s_data};
				else rx_pay <= {rx_pay[71:0], LINK.d2s_data};
			end
			if (got_bcast | got_reply) PEER_LQ_O <= rx_hdr[15:8];
		end
	end
endmodule

// ### tb/radio_link_props.sv
// framing checker for both directions of the radio link
`timescale 1ns/10ps
module radio_link_props (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic d2s_valid,
	input wire logic d2s_ready,
	input wire logic [7:0] d2s_data,
	input wire logic d2s_last,
	input wire logic s2d_valid,
	input wire logic s2d_ready,
	input wire logic [7:0] s2d_data,
	input wire logic s2d_last
);
	// ****************************************
	// byte position tracking
	// ****************************************
	logic [4:0] d_idx;
	logic [4:0] s_idx;
	logic [7:0] d_cmd;
	logic [7:0] s_cmd;
	logic [8:0] d_stall;
	wire [7:0] fc_hi = radio_pkt_pkg::FRAME_CTRL[15:8];
	wire [7:0] fc_lo = radio_pkt_pkg::FRAME_CTRL[7:0];
	wire d_take = d2s_valid & d2s_ready;
	wire s_take = s2d_valid & s2d_ready;
	wire d_stuck = d2s_valid & ~d2s_ready;
	wire [4:0] next_d_idx = d2s_last ? 5'h00 : d_idx + 5'h01;
	wire [4:0] next_s_idx = s2d_last ? 5'h00 : s_idx + 5'h01;
	// dongle valid only falls mid-packet on abort, so its position restarts there
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			d_idx <= 5'h00;
			s_idx <= 5'h00;
			d_cmd <= 8'h00;
			s_cmd <= 8'h00;
			d_stall <= 9'h000;
		end else begin
			d_idx <= d_take ? next_d_idx : (d2s_valid ? d_idx : 5'h00);
			s_idx <= s_take ? next_s_idx : s_idx;
			d_cmd <= (d_take && d_idx == 5'h05) ? d2s_data : d_cmd;
			s_cmd <= (s_take && s_idx == 5'h05) ? s2d_data : s_cmd;
			d_stall <= d_stuck ? d_stall + 9'h001 : 9'h000;
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RST_I);
	sequence s_d_end;
		d2s_valid && d2s_ready && d2s_last;
	endsequence
	sequence s_s_end;
		s2d_valid && s2d_ready && s2d_last;
	endsequence
	property p_d_fc;
		d2s_valid && d_idx < 5'h02 |-> d2s_data == (d_idx == 5'h00 ? fc_hi : fc_lo);
	endproperty
	property p_s_fc;
		s2d_valid && s_idx < 5'h02 |-> s2d_data == (s_idx == 5'h00 ? fc_hi : fc_lo);
	endproperty
	property p_d_cmd;
		d2s_valid && d_idx == 5'h05 |-> d2s_data inside {8'h61, 8'h62, 8'h6b, 8'h73};
	endproperty
	property p_s_cmd;
		s2d_valid && s_idx == 5'h05 |-> s2d_data inside {8'h63, 8'h64};
	endproperty
	property p_d_len;
		d2s_valid && d2s_last |-> d_idx == 5'h05 && d2s_data inside {8'h61, 8'h62}
			|| d_idx == 5'h06 && d_cmd == 8'h73 || d_idx == 5'h0b && d_cmd == 8'h6b;
	endproperty
	property p_s_len;
		s2d_valid && s2d_last |-> s_idx == 5'h0b && s_cmd == 8'h63
			|| s_idx == 5'h0f && s_cmd == 8'h64;
	endproperty
	property p_d_gap;
		s_d_end |=> !d2s_ready;
	endproperty
	property p_s_gap;
		s_s_end |=> !s2d_ready;
	endproperty
	property p_d_hold;
		d_stuck |=> !d2s_valid || $stable(d2s_data) && $stable(d2s_last);
	endproperty
	// a stalled byte may wait for the timeout and no longer
	property p_d_stall;
		d_stuck |-> d_stall <= 9'(radio_pkt_pkg::TX_TIMEOUT_CYC);
	endproperty
	a_d_fc: assert property (p_d_fc) else $error("dongle frame control wrong");
	a_s_fc: assert property (p_s_fc) else $error("sensor frame control wrong");
	a_d_cmd: assert property (p_d_cmd) else $error("dongle command wrong");
	a_s_cmd: assert property (p_s_cmd) else $error("sensor command wrong");
	a_d_len: assert property (p_d_len) else $error("dongle packet length wrong");
	a_s_len: assert property (p_s_len) else $error("sensor packet length wrong");
	a_d_gap: assert property (p_d_gap) else $error("sensor ready after last byte");
	a_s_gap: assert property (p_s_gap) else $error("dongle ready after last byte");
	a_d_hold: assert property (p_d_hold) else $error("dongle byte changed in stall");
	a_d_stall: assert property (p_d_stall) else $error("dongle stall too long");
endmodule

// ### tb/sensor_radio_packet_protocol_tb.sv
// self-checking bench joining the dongle and the sensor ends
`timescale 1ns/10ps
module sensor_radio_packet_protocol_tb;
	typedef struct {
		logic [79:0] smp;
		logic [7:0] lq;
	} row_s;
	row_s rows [3] = '{'{80'h0102030405060708090a, 8'h11}, '{80'hfffefdfcfbfaf9f8f7f6, 8'h00},
		'{80'h80000000000000000001, 8'hff}};
	logic clk = 1'b0, rst = 1'b1, d_hold = 1'b0, s_ce = 1'b1, smp_rdy = 1'b1;
	logic cal_req = 1'b0, rng_req = 1'b0;
	logic [1:0] rng = 2'h0;
	logic [7:0] d_lq = 8'h5a, s_lq = 8'h00;
	logic [47:0] cal_data = 48'h0;
	logic [79:0] s_smp = 80'h0;
	logic d_conn, d_abort, smp_vld, s_conn;
	logic [15:0] d_net, s_net, old_net;
	logic [7:0] d_plq, s_plq;
	logic [47:0] d_cal, s_cal;
	logic [79:0] smp, got;
	logic [1:0] s_rng;
	int err_total = 0, n_checks = 0;
	// holding only the dongle in reset silences one end of a live link
	wire d_rst = rst | d_hold;
	// ****************************************
	// both ends and the checker
	// ****************************************
	radio_link_if u_radio_link_if ();
	radio_dongle #(.LOSS_WAIT(300), .CONNECT_WAIT(400)) u_radio_dongle (
		.CORE_CLK_I(clk), .RST_I(d_rst), .CE_I(1'b1), .LINK(u_radio_link_if.dongle_mp),
		.LQ_I(d_lq), .CAL_REQ_I(cal_req), .CAL_DATA_I(cal_data), .RANGE_REQ_I(rng_req),
		.RANGE_I(rng), .CONNECTED_O(d_conn), .NET_ID_O(d_net), .PEER_LQ_O(d_plq),
		.CAL_STORED_O(d_cal), .TX_ABORT_O(d_abort), .SAMPLE_VALID_O(smp_vld),
		.SAMPLE_READY_I(smp_rdy), .SAMPLE_O(smp)
	);
	radio_sensor #(.SAMPLE_PERIOD(200), .LISTEN_WINDOW(100)) u_radio_sensor (
		.CORE_CLK_I(clk), .RST_I(rst), .CE_I(s_ce), .LINK(u_radio_link_if.sensor_mp),
		.LQ_I(s_lq), .SAMPLE_I(s_smp), .CONNECTED_O(s_conn), .NET_ID_O(s_net),
		.PEER_LQ_O(s_plq), .CAL_O(s_cal), .RANGE_O(s_rng)
	);
	radio_link_props u_radio_link_props (
		.CORE_CLK_I(clk), .RST_I(d_rst),
		.d2s_valid(u_radio_link_if.d2s_valid), .d2s_ready(u_radio_link_if.d2s_ready),
		.d2s_data(u_radio_link_if.d2s_data), .d2s_last(u_radio_link_if.d2s_last),
		.s2d_valid(u_radio_link_if.s2d_valid), .s2d_ready(u_radio_link_if.s2d_ready),
		.s2d_data(u_radio_link_if.s2d_data), .s2d_last(u_radio_link_if.s2d_last)
	);
	// ****************************************
	// helpers
	// ****************************************
	initial begin
		forever #5 clk = ~clk;
	end
	task check(input logic [79:0] got_v, input logic [79:0] exp_v);
		n_checks++;
		if (got_v !== exp_v) begin
			err_total++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got_v, exp_v);
		end
	endtask
	// settled read at the falling edge, popped at the next rising edge
	task get_sample;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (smp_vld !== 1'b1 && n < 1000);
		got = smp;
		@(posedge clk);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// watchdog well beyond the longest expected run
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		give_verdict();
	end
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		check({d_conn, s_conn, smp_vld, s_rng, s_cal}, {3'h0, 2'h0, 48'h0});
		@(posedge clk);
		rst <= 1'b0;
		$display("test reset done");
		repeat (3000) if (!(d_conn === 1'b1 && s_conn === 1'b1)) @(negedge clk);
		check({d_conn, s_conn}, 2'h3);
		check(d_net, s_net);
		check(d_cal, s_cal);
		$display("test connect done");
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			s_smp <= rows[i].smp;
			s_lq <= rows[i].lq;
			get_sample();
			get_sample();
			check(got, rows[i].smp);
			check(d_plq, rows[i].lq);
		end
		$display("test samples done");
		@(posedge clk);
		smp_rdy <= 1'b0;
		repeat (650) @(posedge clk);
		smp_rdy <= 1'b1;
		@(negedge clk);
		check({smp_vld, smp}, {1'b1, rows[2].smp});
		@(negedge clk);
		check({smp_vld, smp}, {1'b1, rows[2].smp});
		$display("test stall done");
		@(posedge clk);
		cal_data <= 48'h123456789abc;
		cal_req <= 1'b1;
		@(posedge clk);
		cal_req <= 1'b0;
		repeat (4000) if (d_cal !== 48'h123456789abc) @(negedge clk);
		check(s_cal, 48'h123456789abc);
		check(d_cal, 48'h123456789abc);
		check(s_plq, d_lq);
		@(posedge clk);
		rng <= 2'h3;
		rng_req <= 1'b1;
		@(posedge clk);
		rng_req <= 1'b0;
		repeat (4000) if (s_rng !== 2'h3) @(negedge clk);
		check(s_rng, 2'h3);
		$display("test settings done");
		@(posedge clk);
		d_hold <= 1'b1;
		repeat (500) @(negedge clk);
		check(s_conn, 1'b1);
		// without faster listening after a miss the drop would come too late
		repeat (1500) if (s_conn !== 1'b0) @(negedge clk);
		check(s_conn, 1'b0);
		@(posedge clk);
		d_hold <= 1'b0;
		repeat (3000) if (!(d_conn === 1'b1 && s_conn === 1'b1)) @(negedge clk);
		check(d_net, s_net);
		$display("test sensor drop done");
		old_net = d_net;
		@(posedge clk);
		s_ce <= 1'b0;
		repeat (900) @(negedge clk);
		check(d_conn, 1'b1);
		repeat (3000) if (d_conn !== 1'b0) @(negedge clk);
		check(d_conn, 1'b0);
		repeat (1500) if (d_abort !== 1'b1) @(negedge clk);
		check(d_abort, 1'b1);
		@(posedge clk);
		s_ce <= 1'b1;
		repeat (8000) if (!(d_conn === 1'b1 && s_conn === 1'b1 && d_net === s_net)) @(negedge clk);
		check(d_net, s_net);
		check(d_net !== old_net, 1'b1);
		$display("test dongle drop done");
		give_verdict();
	end
endmodule
